//--- rtl/req_mask_map.svh
`ifndef REQ_MASK_MAP_SVH
`define REQ_MASK_MAP_SVH

// Register offsets
`define SAMPLE_TRIGGER_OFS 8'h05
`define TYPEC_COMMAND_OFS 8'h06
`define INT_MASK_0_OFS 8'h07
`define FLAGS_0_OFS 8'h0a

// Field positions
`define SAMPLE_REQ_BIT 0
`define SOURCE_RESET_BIT 0
`define FORCE_ERROR_BIT 1
`define AUTO_CLEAR_BIT 7
`define STATE_CHANGE_BIT 5
`define TYPEC_ATT_STAT_BIT 4
`define CHG_ATT_STAT_BIT 3
`define TYPEC_ATT_EV_BIT 2
`define CHG_ATT_EV_BIT 1
`define MEAS_DONE_BIT 0

// Reset values and widths
`define INT_MASK_0_RST 8'h00
`define FLAG_COUNT 6
`define MASK_WRITABLE 8'hbf
`endif

//--- rtl/req_mask_pkg.sv
package req_mask_pkg;
    // Sample trigger sequencing, one-hot
    typedef enum logic [1:0]
    {
        SAMPLE_IDLE = 2'b01,
        SAMPLE_BUSY = 2'b10
    } sample_state_t;

    typedef logic [7:0] reg_byte_t;
    typedef logic [5:0] flag_vec_t;
endpackage : req_mask_pkg

//--- rtl/flag_bank_if.sv
interface flag_bank_if;
    logic [5:0] cond;
    logic auto_clear;
    logic read_clear;
    logic [5:0] flags;

    modport owner
    (
        output cond,
        output auto_clear,
        output read_clear,
        input flags
    );

    modport bank
    (
        input cond,
        input auto_clear,
        input read_clear,
        output flags
    );
endinterface : flag_bank_if

//--- rtl/flag_bank.sv
`include "req_mask_map.svh"

module flag_bank
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    flag_bank_if.bank fb
);
    logic [5:0] flags_q;

    assign fb.flags = flags_q;

    // One latch cell per condition; a condition seen in the read cycle wins over the clear
    genvar i;
    generate
        for (i = 0; i < `FLAG_COUNT; i = i + 1)
        begin : g_flag
            always_ff @(posedge sys_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    flags_q[i] <= 1'b0;
                end
                else if (fb.auto_clear)
                begin
                    flags_q[i] <= fb.cond[i];
                end
                else
                begin
                    flags_q[i] <= fb.cond[i] | (flags_q[i] & ~fb.read_clear);
                end
            end
        end
    endgenerate
endmodule : flag_bank

//--- rtl/request_and_irq_mask_regs.sv
`include "req_mask_map.svh"

module request_and_irq_mask_regs
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output req_mask_pkg::reg_byte_t reg_rdata_o,
    output logic meas_start_o,
    input wire logic meas_done_i,
    output logic typec_force_error_recovery_o,
    output logic typec_source_state_reset_o,
    input wire logic typec_state_change_i,
    input wire logic typec_attach_status_i,
    input wire logic charger_attach_status_i,
    input wire logic typec_attach_event_i,
    input wire logic charger_attach_event_i,
    output logic irq_o
);
    import req_mask_pkg::*;

    sample_state_t sample_q;
    reg_byte_t mask_q;
    reg_byte_t rdata_q;
    logic start_q;
    logic force_err_q;
    logic src_rst_q;
    logic irq_q;
    logic wr_trig;
    logic wr_cmd;
    logic wr_mask;
    logic rd_flags;
    logic done_q;
    logic done_rise;

    // Bundle toward the flag cells
    flag_bank_if fb ();

    // Address decode; each strobe qualifies only its own offset, writes elsewhere fall away
    always_comb
    begin
        wr_trig = 1'b0;
        wr_cmd = 1'b0;
        wr_mask = 1'b0;
        rd_flags = 1'b0;
        case (reg_addr_i)
            `SAMPLE_TRIGGER_OFS:
            begin
                wr_trig = reg_wr_i;
            end
            `TYPEC_COMMAND_OFS:
            begin
                wr_cmd = reg_wr_i;
            end
            `INT_MASK_0_OFS:
            begin
                wr_mask = reg_wr_i;
            end
            `FLAGS_0_OFS:
            begin
                rd_flags = reg_rd_i;
            end
            default:
            begin
                rd_flags = 1'b0;
            end
        endcase
    end

    // Conditions in flag order; the measurement engine's done pulse feeds bit 0
    assign fb.cond = {typec_state_change_i, typec_attach_status_i, charger_attach_status_i,
                      typec_attach_event_i, charger_attach_event_i, meas_done_i};
    assign fb.auto_clear = mask_q[`AUTO_CLEAR_BIT];
    assign fb.read_clear = rd_flags;

    flag_bank u_flags
    (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .fb(fb)
    );

    // Done edge: a done level left high from the previous sample must not end the next one early
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= meas_done_i;
        end
    end

    // Limitation: the engine must drop done between samples, or a pending sample never ends
    assign done_rise = meas_done_i && !done_q;

    // Sample trigger: a second request while busy is dropped, one sample per request
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sample_q <= SAMPLE_IDLE;
        end
        else
        begin
            case (sample_q)
                SAMPLE_IDLE:
                begin
                    if (wr_trig && reg_wdata_i[`SAMPLE_REQ_BIT])
                    begin
                        sample_q <= SAMPLE_BUSY;
                    end
                end
                SAMPLE_BUSY:
                begin
                    if (done_rise)
                    begin
                        sample_q <= SAMPLE_IDLE;
                    end
                end
                default:
                begin
                    sample_q <= SAMPLE_IDLE;
                end
            endcase
        end
    end

    // Start strobe: one cycle wide, raised only for a request taken while idle
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= wr_trig && reg_wdata_i[`SAMPLE_REQ_BIT] && (sample_q == SAMPLE_IDLE);
        end
    end

    // Force-error strobe; the command is not stored, so a read finds nothing
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            force_err_q <= 1'b0;
        end
        else
        begin
            force_err_q <= wr_cmd && reg_wdata_i[`FORCE_ERROR_BIT];
        end
    end

    // Source-reset strobe; may pulse together with force-error when both bits are written
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            src_rst_q <= 1'b0;
        end
        else
        begin
            src_rst_q <= wr_cmd && reg_wdata_i[`SOURCE_RESET_BIT];
        end
    end

    // Mask register; bit 6 is not implemented and stays zero
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mask_q <= `INT_MASK_0_RST;
        end
        else if (wr_mask)
        begin
            mask_q <= reg_wdata_i & `MASK_WRITABLE;
        end
    end

    // Interrupt from enabled flags; registered so the pin never glitches
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(fb.flags & mask_q[5:0]);
        end
    end

    // Read data, one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_q <= 8'h00;
        end
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `SAMPLE_TRIGGER_OFS:
                begin
                    rdata_q <= {7'h00, sample_q == SAMPLE_BUSY};
                end
                `TYPEC_COMMAND_OFS:
                begin
                    rdata_q <= 8'h00;
                end
                `INT_MASK_0_OFS:
                begin
                    rdata_q <= mask_q;
                end
                `FLAGS_0_OFS:
                begin
                    rdata_q <= {2'h0, fb.flags};
                end
                default:
                begin
                    rdata_q <= 8'h00;
                end
            endcase
        end
    end

    // Every output is a flop, wired straight to its pin
    assign reg_rdata_o = rdata_q;
    assign meas_start_o = start_q;
    assign typec_force_error_recovery_o = force_err_q;
    assign typec_source_state_reset_o = src_rst_q;
    assign irq_o = irq_q;
endmodule : request_and_irq_mask_regs

//--- verif/req_mask_props.sv
module req_mask_props
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire req_mask_pkg::reg_byte_t reg_rdata_o,
    input wire logic meas_start_o,
    input wire logic meas_done_i,
    input wire logic typec_force_error_recovery_o,
    input wire logic typec_source_state_reset_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import req_mask_pkg::*;
    logic wr_trig;
    logic wr_cmd;
    // Decoded write strobes
    assign wr_trig = reg_wr_i && reg_addr_i == 8'h05;
    assign wr_cmd = reg_wr_i && reg_addr_i == 8'h06;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_start_cause: assert property ($rose(meas_start_o) |-> $past(wr_trig && reg_wdata_i[0]))
        else $error("start without trigger");
    a_start_pulse: assert property (meas_start_o |=> !meas_start_o)
        else $error("start too long");
    a_zero_idle: assert property (wr_trig && !reg_wdata_i[0] |=> !meas_start_o)
        else $error("start on zero");
    a_busy_read: assert property (((meas_start_o && !meas_done_i) ##1 (reg_rd_i && reg_addr_i == 8'h05 && !meas_done_i)) |=> reg_rdata_o == 8'h01)
        else $error("pending bit low");
    a_err_pulse: assert property (wr_cmd && reg_wdata_i[1] |=> typec_force_error_recovery_o)
        else $error("no error recovery");
    a_err_cause: assert property (typec_force_error_recovery_o |-> $past(wr_cmd && reg_wdata_i[1]))
        else $error("stray error recovery");
    a_reset_pulse: assert property (wr_cmd && reg_wdata_i[0] |=> typec_source_state_reset_o)
        else $error("no source reset");
    a_reset_cause: assert property (typec_source_state_reset_o |-> $past(wr_cmd && reg_wdata_i[0]))
        else $error("stray source reset");
    a_cmd_zero: assert property (reg_rd_i && reg_addr_i == 8'h06 |=> reg_rdata_o == 8'h00)
        else $error("command reads nonzero");
    a_flag_top: assert property (reg_rd_i && reg_addr_i == 8'h0a |=> reg_rdata_o[7:6] == 2'b00)
        else $error("flag top bits set");
endmodule : req_mask_props

bind request_and_irq_mask_regs req_mask_props u_req_mask_props (.*);

//--- verif/request_and_irq_mask_regs_bench.sv
module request_and_irq_mask_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import req_mask_pkg::*;
    logic sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, meas_start_o, irq_o;
    logic typec_force_error_recovery_o, typec_source_state_reset_o;
    logic [7:0] reg_addr_i, reg_wdata_i, m;
    reg_byte_t reg_rdata_o, rv;
    logic [5:0] cond, b;
    wire logic meas_done_i, typec_state_change_i, typec_attach_status_i;
    wire logic charger_attach_status_i, typec_attach_event_i, charger_attach_event_i;
    int error_cnt, tests_run;
    // Conditions in flag order, bit 5 first
    assign {typec_state_change_i, typec_attach_status_i, charger_attach_status_i, typec_attach_event_i,
        charger_attach_event_i, meas_done_i} = cond;
    request_and_irq_mask_regs u_request_and_irq_mask_regs (.*);
    // 100 ns clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    function automatic logic exp_irq(input logic [5:0] f, input logic [7:0] k);
        return |(f & k[5:0]);
    endfunction : exp_irq
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
    endtask : wr
    // Extra cycle lets read data and read-clear settle
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        tick(1);
        reg_rd_i = 1'b0;
        tick(1);
        rv = reg_rdata_o;
    endtask : rd
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // Watchdog against a hung run
    initial
    begin
        #2000000;
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, nrst_i, cond} = '0;
        void'($urandom(92568));
        tick(4);
        nrst_i = 1'b1;
        rd(8'h07);
        chk("mask reset", 8'h00, rv);
        rd(8'h20);
        chk("unmapped", 8'h00, rv);
        repeat (4)
        begin
            m = 8'($urandom);
            wr(8'h07, m);
            rd(8'h07);
            chk("mask", m & 8'hbf, rv);
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h06, 8'(i));
            chk("force error", 8'(i[1]), typec_force_error_recovery_o);
            chk("source reset", 8'(i[0]), typec_source_state_reset_o);
            rd(8'h06);
            chk("command read", 8'h00, rv);
        end
        $display("test commands done");
        wr(8'h05, 8'h00);
        chk("no start", 8'h00, meas_start_o);
        wr(8'h05, 8'h01);
        chk("start", 8'h01, meas_start_o);
        rd(8'h05);
        chk("pending", 8'h01, rv);
        wr(8'h05, 8'h01);
        chk("busy start", 8'h00, meas_start_o);
        cond = 6'h01;
        tick(1);
        cond = 6'h00;
        rd(8'h05);
        chk("cleared", 8'h00, rv);
        $display("test sample done");
        // Latched mode, one enable at a time
        for (int i = 0; i < 6; i++)
        begin
            rd(8'h0a);
            b = 6'h01 << i;
            wr(8'h07, {2'b00, b});
            cond = ~b;
            tick(1);
            cond = 6'h00;
            tick(2);
            chk("irq masked", 8'h00, irq_o);
            rd(8'h0a);
            chk("sticky flags", {2'b00, ~b}, rv);
            cond = b;
            tick(1);
            cond = 6'h00;
            tick(2);
            chk("irq enabled", 8'h01, irq_o);
            rd(8'h0a);
            chk("flag order", {2'b00, b}, rv);
            tick(1);
            chk("irq read clear", 8'h00, irq_o);
        end
        // Condition and read-clear in one cycle: the set must win
        wr(8'h07, 8'h3f);
        @(negedge sys_clk_i);
        {reg_addr_i, reg_rd_i, cond} = {8'h0a, 1'b1, 6'h2a};
        tick(1);
        {reg_rd_i, cond} = 7'h00;
        rd(8'h0a);
        chk("set wins", 8'h2a, rv);
        $display("test latched done");
        // Auto-clear mode, random conditions and enables
        repeat (4)
        begin
            m = 8'($urandom) | 8'h80;
            wr(8'h07, m);
            cond = 6'($urandom);
            tick(3);
            chk("auto irq", 8'(exp_irq(cond, m)), irq_o);
            rd(8'h0a);
            chk("auto flags", {2'b00, cond}, rv);
            cond = 6'h00;
            tick(3);
            chk("auto irq off", 8'h00, irq_o);
        end
        $display("test auto clear done");
        end_of_test();
    end
endmodule : request_and_irq_mask_regs_bench
